// >>> hdl/ccg_clock_ctrl.sv
// Strap capture, output clock generation and stop gating of the clock synthesizer.
// Assumes pins and the oscillator are asynchronous; serial overrides come from logic on clk_in.
`timescale 1ns/10ps
module ccg_clock_ctrl #(
   parameter int STRAP_EDGES = ccg_pkg::STRAP_REF_EDGES
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic osc_in,
   input wire logic clk_stop_n_in,
   input wire logic serial_sel_in,
   input wire logic [3:0] serial_code_in,
   input wire logic [4:0] dual_pin_in,
   input wire logic ref_clk_a_in,
   output logic [4:0] dual_pin_out,
   output logic [4:0] dual_pin_oe_n_out,
   output logic ref_clk_a_out,
   output logic ref_clk_a_oe_n_out,
   output logic osc_out_out,
   output logic cpu_clk_free_out,
   output logic cpu_clk_gated_out,
   output logic intr_ctrl_clk_out,
   output logic [3:0] pci_clk_gated_upper_out,
   output logic [3:0] freq_select_code_out,
   output logic mode_out,
   output logic strap_done_out
);

   localparam int CW = $clog2(STRAP_EDGES + 1);
   localparam logic [CW-1:0] EDGE_LAST = CW'(STRAP_EDGES - 1);

   ////////////////////////////////////////////////////////////////////////////////
   // Two-flop synchroniser for every asynchronous input
   logic [ccg_pkg::SY_W-1:0] sy1_reg;
   logic [ccg_pkg::SY_W-1:0] sy2_reg;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         sy1_reg <= '0;
         sy2_reg <= '0;
      end
      else
      begin
         sy1_reg <= {ref_clk_a_in, clk_stop_n_in, osc_in, dual_pin_in};
         sy2_reg <= sy1_reg;
      end
   end

   logic osc_s;
   logic stop_s;
   assign osc_s = sy2_reg[ccg_pkg::SY_OSC];
   assign stop_s = sy2_reg[ccg_pkg::SY_STOP];

   ////////////////////////////////////////////////////////////////////////////////
   // Strap window, straps and reference phase
   ccg_pkg::ccg_state_t state_reg, state_next;
   logic [CW-1:0] edge_cnt_reg, edge_cnt_next;
   ccg_pkg::ccg_strap_t strap_reg, strap_next;
   logic osc_q_reg, osc_q_next;
   logic osc_rise;

   assign osc_rise = osc_s & ~osc_q_reg;

   // Pins stay released while reference edges are counted; levels caught once at the end
   always_comb
   begin
      state_next = state_reg;
      edge_cnt_next = edge_cnt_reg;
      strap_next = strap_reg;
      osc_q_next = osc_s;
      case (state_reg)
         ccg_pkg::ST_STRAP:
         begin
            if (osc_rise)
            begin
               edge_cnt_next = edge_cnt_reg + CW'(1);
               if (edge_cnt_reg == EDGE_LAST)
               begin
                  strap_next = sy2_reg[ccg_pkg::DUAL_PINS-1:0];
                  state_next = ccg_pkg::ST_RUN;
               end
            end
         end
         ccg_pkg::ST_RUN: strap_next = strap_reg;
         default: state_next = ccg_pkg::ST_STRAP;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_reg <= ccg_pkg::ST_STRAP;
         edge_cnt_reg <= '0;
         strap_reg <= ccg_pkg::STRAP_RST;
         osc_q_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         edge_cnt_reg <= edge_cnt_next;
         strap_reg <= strap_next;
         osc_q_reg <= osc_q_next;
      end
   end

   logic done;
   logic stop_pin_mode;
   assign done = (state_reg == ccg_pkg::ST_RUN);
   assign stop_pin_mode = done && (strap_reg.mode == ccg_pkg::MODE_STOP_PIN);

   ////////////////////////////////////////////////////////////////////////////////
   // CPU and PCI phase, 48/24 MHz dividers, PCI stop sampling
   logic cpu_ph_reg, cpu_ph_next;
   logic [2:0] pci_cnt_reg, pci_cnt_next;
   logic pci_ph_reg, pci_ph_next;
   logic pci_smp_reg, pci_smp_next;
   logic [6:0] acc_reg, acc_next;
   logic [7:0] acc_sum;
   logic usb_reg, usb_next;
   logic sio_reg, sio_next;
   logic [2:0] ratio;
   logic [3:0] code;
   logic pci_start;

   // Serial selection overrides the strap code
   assign code = serial_sel_in ? serial_code_in : strap_reg.fs;
   assign ratio = ccg_pkg::ccg_pci_ratio(code);

   // PCI period is 2*ratio system cycles, i.e. ratio CPU periods; free clocks never stop
   always_comb
   begin
      cpu_ph_next = ~cpu_ph_reg;
      pci_cnt_next = pci_cnt_reg + 3'h1;
      // Compared at four bits: twice a ratio of four does not fit the counter width
      if ({1'b0, pci_cnt_reg} >= {ratio, 1'b0} - 4'h1)
         pci_cnt_next = 3'h0;
      pci_ph_next = (pci_cnt_next < ratio);
      pci_start = (pci_cnt_next == 3'h0);
      pci_smp_next = pci_smp_reg;
      if (pci_start)
         pci_smp_next = stop_pin_mode ? sy2_reg[ccg_pkg::SY_PIN2] : 1'b1;
      // Sum kept one bit wider: 99 plus 96 would wrap a 7-bit accumulator and lose toggles
      acc_sum = {1'b0, acc_reg} + {1'b0, ccg_pkg::ACC_STEP};
      acc_next = acc_sum[6:0];
      usb_next = usb_reg;
      if (acc_sum >= {1'b0, ccg_pkg::ACC_WRAP})
      begin
         acc_next = 7'(acc_sum - {1'b0, ccg_pkg::ACC_WRAP});
         usb_next = ~usb_reg;
      end
      sio_next = (usb_next & ~usb_reg) ? ~sio_reg : sio_reg;
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cpu_ph_reg <= 1'b0;
         pci_cnt_reg <= 3'h0;
         pci_ph_reg <= 1'b0;
         pci_smp_reg <= 1'b1;
         acc_reg <= 7'h00;
         usb_reg <= 1'b0;
         sio_reg <= 1'b0;
      end
      else
      begin
         cpu_ph_reg <= cpu_ph_next;
         pci_cnt_reg <= pci_cnt_next;
         pci_ph_reg <= pci_ph_next;
         pci_smp_reg <= pci_smp_next;
         acc_reg <= acc_next;
         usb_reg <= usb_next;
         sio_reg <= sio_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Whole-cycle gates; a mid-cycle stop waits for the next cycle start, or for the start after it on PCI
   logic cpu_run;
   logic apic_run;
   logic pci_run;
   logic [4:0] pci_g;

   ccg_gate #(.W(1)) u_cpu_gate (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .start_in(~cpu_ph_reg),
      .run_in(stop_s),
      .src_next_in(cpu_ph_next),
      .gated_out(cpu_clk_gated_out),
      .run_out(cpu_run)
   );

   ccg_gate #(.W(1)) u_apic_gate (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .start_in(osc_s & ~osc_q_reg),
      .run_in(stop_s),
      .src_next_in(osc_s),
      .gated_out(intr_ctrl_clk_out),
      .run_out(apic_run)
   );

   // The sample taken at this start steers the next cycle, not this one
   ccg_gate #(.W(5)) u_pci_gate (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .start_in(pci_start),
      .run_in(pci_smp_reg),
      .src_next_in(pci_ph_next),
      .gated_out(pci_g),
      .run_out(pci_run)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Reference copies and pin drivers; drivers enable only after straps are caught
   logic ref_reg;
   logic done_reg;
   logic [4:0] oe_n_reg;
   logic ref_oe_n_reg;
   logic osc_out_reg;

   // Enables registered so that no pin driver sees a decode glitch
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ref_reg <= 1'b0;
         done_reg <= 1'b0;
         oe_n_reg <= 5'h1f;
         ref_oe_n_reg <= 1'b1;
         osc_out_reg <= 1'b1;
      end
      else
      begin
         ref_reg <= osc_s;
         done_reg <= done;
         oe_n_reg <= {5{~done}};
         ref_oe_n_reg <= ~(done & strap_reg.mode);
         osc_out_reg <= ~osc_s;
      end
   end

   assign dual_pin_out = {pci_ph_reg, pci_g[0], ref_reg, sio_reg, usb_reg};
   assign dual_pin_oe_n_out = oe_n_reg;
   assign ref_clk_a_out = ref_reg;
   assign ref_clk_a_oe_n_out = ref_oe_n_reg;
   assign osc_out_out = osc_out_reg;
   assign cpu_clk_free_out = cpu_ph_reg;
   assign pci_clk_gated_upper_out = pci_g[4:1];
   assign freq_select_code_out = strap_reg.fs;
   assign mode_out = strap_reg.mode;
   assign strap_done_out = done_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   a_strap_hiz: assert property (!done_reg |-> (&dual_pin_oe_n_out) && ref_clk_a_oe_n_out)
      else $error("dual pins driven during strap window");
   a_strap_hold: assert property (done && $past(done) |-> $stable(strap_reg))
      else $error("strap value changed after latch");
   a_pci_count: assert property ($stable(ratio) |-> {1'b0, pci_cnt_reg} < {ratio, 1'b0})
      else $error("pci divider out of range");
   a_cpu_free_run: assert property ($past(rst_n_in) |-> cpu_clk_free_out != $past(cpu_clk_free_out))
      else $error("free cpu clock stalled");
   a_pci_free_run: assert property ($rose(pci_ph_reg) |-> ##[2:8] $fell(pci_ph_reg))
      else $error("free pci clock stalled");
   a_cpu_stop_lat: assert property ($fell(stop_s) |-> ##[1:2] !cpu_run ##1 !cpu_clk_gated_out)
      else $error("cpu stop latency wrong");
   a_cpu_start_lat: assert property ($rose(stop_s) |-> ##[1:2] cpu_run ##0 cpu_clk_gated_out)
      else $error("cpu restart missing full pulse");
   a_gate_whole: assert property ($changed(cpu_run) |-> cpu_ph_reg)
      else $error("cpu gate changed mid cycle");
   a_pci_stop_low: assert property (!pci_run |-> pci_g == 5'h00)
      else $error("gated pci clock ran while stopped");
   a_pci_sample_next: assert property ($changed(pci_run) |-> pci_run == $past(pci_smp_reg))
      else $error("pci stop applied early");
   a_apic_stop: assert property (!apic_run |-> !intr_ctrl_clk_out)
      else $error("interrupt clock ran while stopped");
   a_mode_pin: assert property (stop_pin_mode |-> ref_clk_a_oe_n_out)
      else $error("shared pin driven in stop mode");

   c_strap_done: cover property ($rose(done_reg));
   c_cpu_stop: cover property ($fell(cpu_run) ##[1:300] $rose(cpu_run));
   c_pci_stop: cover property ($fell(pci_run));
   c_ratio_four: cover property (ratio == 3'h4 && $rose(pci_ph_reg));

endmodule

// >>> hdl/ccg_pkg.sv
// Shared constants, strap carrier and state encoding for the clock gating block.
// Assumes a 100 MHz system clock and a reference oscillator near 14.318 MHz.
package ccg_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Rates and times
   localparam int CLK_MHZ = 100;
   localparam int REF_KHZ = 14318;
   localparam int STRAP_TIME_US = 2000;
   // Longest strap window, counted in reference edges, rounded down
   localparam int STRAP_REF_EDGES = STRAP_TIME_US * REF_KHZ / 1000;
   // Toggle rate of the 48 MHz output, averaged by a phase accumulator
   localparam int USB_TOGGLE_MHZ = 96;
   localparam logic [6:0] ACC_STEP = 7'(USB_TOGGLE_MHZ);
   localparam logic [6:0] ACC_WRAP = 7'(CLK_MHZ);

   ////////////////////////////////////////////////////////////////////////////////
   // Dual-purpose pin positions
   localparam int PIN_USB_FS0 = 0;
   localparam int PIN_SIO_FS1 = 1;
   localparam int PIN_REFB_FS2 = 2;
   localparam int PIN_PCI_CLK_GATED_SEL_BIT3 = 3;
   localparam int PIN_PCIF_MODE = 4;
   localparam int DUAL_PINS = 5;

   // Synchroniser positions
   localparam int SY_OSC = 5;
   localparam int SY_STOP = 6;
   localparam int SY_PIN2 = 7;
   localparam int SY_W = 8;

   ////////////////////////////////////////////////////////////////////////////////
   // Strap carrier and reset value
   typedef struct packed {
      logic mode;
      logic [3:0] fs;
   } ccg_strap_t;
   localparam ccg_strap_t STRAP_RST = 5'h00;
   localparam logic MODE_STOP_PIN = 1'h0;

   typedef enum logic {
      ST_STRAP = 1'b0,
      ST_RUN = 1'b1
   } ccg_state_t;

   // PCI divide ratio from the select code
   function automatic logic [2:0] ccg_pci_ratio(input logic [3:0] code);
      logic [2:0] r;
      r = 3'h2;
      if (code[3:2] == 2'h3)
         r = 3'h4;
      else if (code[3:2] != 2'h0 || code == 4'h0)
         r = 3'h3;
      return r;
   endfunction

endpackage

// >>> hdl/ccg_gate.sv
// Whole-cycle clock gate: the run decision changes only at the start of a clock cycle.
// Assumes start_in pulses in the cycle before the source rises and src_next_in is its next level.
`timescale 1ns/10ps
module ccg_gate #(
   parameter int W = 1
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic start_in,
   input wire logic run_in,
   input wire logic src_next_in,
   output logic [W-1:0] gated_out,
   output logic run_out
);

   logic run_reg;
   logic run_next;
   logic [W-1:0] gated_reg;
   logic [W-1:0] gated_next;

   ////////////////////////////////////////////////////////////////////////////////
   // A stop at a cycle start leaves the previous cycle complete; a start gives a full first pulse
   always_comb
   begin
      run_next = start_in ? run_in : run_reg;
      gated_next = {W{src_next_in & run_next}};
   end

   // Registers only
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         run_reg <= 1'b0;
         gated_reg <= '0;
      end
      else
      begin
         run_reg <= run_next;
         gated_reg <= gated_next;
      end
   end

   assign gated_out = gated_reg;
   assign run_out = run_reg;

endmodule

// >>> test/ccg_far_model.sv
// Far-side model: reference oscillator, strap resistors and the shared stop pin.
// Assumes the bench sets strap and stop levels; a driven pin shows the device level.
`timescale 1ns/10ps
module ccg_far_model (
   input wire logic [4:0] strap_in,
   input wire logic pci_stop_n_in,
   input wire logic [4:0] pin_drv_in,
   input wire logic [4:0] pin_oe_n_in,
   input wire logic ref_drv_in,
   input wire logic ref_oe_n_in,
   output logic osc_out,
   output logic [4:0] pin_out,
   output logic ref_pin_out
);
   ////////////////////////////////////////////////////////////////////////////////
   // Oscillator near 14.318 MHz, free running and unrelated to clk_in
   initial
   begin
      osc_out = 1'b0;
      forever #34.92 osc_out = ~osc_out;
   end
   // Released pins sit at the resistor level, driven pins follow the device
   assign pin_out = (pin_oe_n_in & strap_in) | (~pin_oe_n_in & pin_drv_in);
   // Stop level is held steady by power management between changes
   assign ref_pin_out = ref_oe_n_in ? pci_stop_n_in : ref_drv_in;
endmodule

// >>> test/ccg_clock_ctrl_tb.sv
// Self-checking bench for the clock control block with a far-side model.
// Assumes a short strap window (8 reference edges) and 100 MHz clk_in.
`timescale 1ns/10ps
module ccg_clock_ctrl_tb;
   logic clk_in, rst_n_in, clk_stop_n, serial_sel, pci_stop_n, osc, ref_in;
   logic ref_o, ref_oe_n, osc_o, cpu_free, cpu_gated, intr_clk, mode, done;
   logic [3:0] serial_code, pci_up, code;
   logic [4:0] strap, pin_in, pin, pin_oe_n;
   logic [7:0] watch;
   int fails, num_checks, hi, lo, k;
   int cnt [8];
   assign watch = {intr_clk, cpu_gated, cpu_free, pci_up[0], pin[4], pin[2], pin[1], pin[0]};
   ccg_clock_ctrl #(.STRAP_EDGES(8)) ccg_clock_ctrl_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .osc_in(osc), .clk_stop_n_in(clk_stop_n), .serial_sel_in(serial_sel),
      .serial_code_in(serial_code), .dual_pin_in(pin_in), .ref_clk_a_in(ref_in),
      .dual_pin_out(pin), .dual_pin_oe_n_out(pin_oe_n), .ref_clk_a_out(ref_o),
      .ref_clk_a_oe_n_out(ref_oe_n), .osc_out_out(osc_o), .cpu_clk_free_out(cpu_free),
      .cpu_clk_gated_out(cpu_gated), .intr_ctrl_clk_out(intr_clk),
      .pci_clk_gated_upper_out(pci_up), .freq_select_code_out(code), .mode_out(mode),
      .strap_done_out(done));
   ccg_far_model ccg_far_model_i (.strap_in(strap), .pci_stop_n_in(pci_stop_n),
      .pin_drv_in(pin), .pin_oe_n_in(pin_oe_n), .ref_drv_in(ref_o), .ref_oe_n_in(ref_oe_n),
      .osc_out(osc), .pin_out(pin_in), .ref_pin_out(ref_in));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock
   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // Comparison and verdict
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic near(input string what, input int seen, input int lo_b, input int hi_b);
      check(what, 32'(seen >= lo_b && seen <= hi_b), 32'h1);
   endtask
   task automatic tally_and_finish();
      if (fails == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Toggle counts per watched output, sampled mid-cycle where outputs are settled
   task automatic count_toggles(input int n);
      logic [7:0] prev;
      for (int i = 0; i < 8; i++) cnt[i] = 0;
      @(negedge clk_in);
      prev = watch;
      repeat (n)
      begin
         @(negedge clk_in);
         for (int i = 0; i < 8; i++) cnt[i] += int'(watch[i] !== prev[i]);
         prev = watch;
      end
   endtask
   // Length of the next run of the free PCI clock at one level, bounded
   task automatic level_len(input logic lvl, output int n);
      int w;
      w = 0;
      n = 0;
      while (pin[4] !== lvl && w < 20)
      begin
         @(negedge clk_in);
         w++;
      end
      while (pin[4] === lvl && n < 20)
      begin
         @(negedge clk_in);
         n++;
      end
      if (w >= 20 || n >= 20)
      begin
         fails++;
         tally_and_finish();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // A bound used up counts as a mismatch and ends the run
   task automatic guard(input int used, input int lim);
      if (used >= lim)
      begin
         fails++;
         tally_and_finish();
      end
   endtask
   // Bounded wait for the strap latch, then one more cycle for the drivers
   task automatic wait_done();
      k = 0;
      while (done !== 1'b1 && k < 200)
      begin
         @(negedge clk_in);
         k++;
      end
      guard(k, 200);
      @(negedge clk_in);
   endtask
   // Straps latched once, then drivers on; mode zero keeps the shared pin an input
   task automatic t_strap();
      check("oe_n in window", pin_oe_n, 5'h1f);
      wait_done();
      check("code", code, 4'hd);
      check("mode", mode, 1'h0);
      check("oe_n after", pin_oe_n, 5'h00);
      check("ref oe_n", ref_oe_n, 1'h1);
   endtask
   // Output rates over 1000 cycles; pins now toggle yet straps must hold
   task automatic t_rates();
      count_toggles(1000);
      near("usb", cnt[0], 958, 962);
      near("superio", cnt[1], 478, 482);
      near("ref b", cnt[2], 284, 289);
      near("intr", cnt[7], 284, 289);
      check("cpu free", cnt[5], 32'd1000);
      check("cpu gated", cnt[6], 32'd1000);
      near("pci free", cnt[3], 249, 251);
      near("pci up", cnt[4], 249, 251);
      check("code held", code, 4'hd);
      check("ref a copy", ref_o, pin[2]);
      check("osc out inverse", osc_o ^ ref_o, 32'h1);
      check("pci1 gated", pin[3], pci_up[0]);
   endtask
   // Every select code through the serial path sets the PCI divide
   task automatic t_ratio();
      logic [3:0] c;
      int exp;
      @(posedge clk_in);
      #1 serial_sel = 1'b1;
      for (int i = 0; i < 16; i++)
      begin
         c = 4'(i);
         exp = (c[3:2] == 2'h3) ? 4 : ((c[3:2] != 2'h0 || c == 4'h0) ? 3 : 2);
         @(posedge clk_in);
         #1 serial_code = c;
         repeat (20) @(posedge clk_in);
         #1;
         level_len(1'b0, lo);
         level_len(1'b1, hi);
         level_len(1'b0, lo);
         check("pci high", hi, exp);
         check("pci low", lo, exp);
      end
      @(posedge clk_in);
      #1 serial_sel = 1'b0;
   endtask
   // Clock stop: held low within the latency, free clock runs, restart whole
   task automatic t_clk_stop();
      @(posedge clk_in);
      #1 clk_stop_n = 1'b0;
      repeat (7) @(negedge clk_in);
      count_toggles(100);
      check("gated stopped", cnt[6], 32'd0);
      check("gated level", cpu_gated, 1'h0);
      check("intr stopped", cnt[7], 32'd0);
      check("free runs", cnt[5], 32'd100);
      @(posedge clk_in);
      #1 clk_stop_n = 1'b1;
      k = 0;
      while (cpu_gated !== 1'b1 && k < 12)
      begin
         @(negedge clk_in);
         k++;
      end
      guard(k, 12);
      near("restart delay", k, 3, 8);
      @(negedge clk_in);
      check("first pulse", cpu_gated, 1'h0);
   endtask
   // PCI stop holds the gated PCI clocks low while the free one runs
   task automatic t_pci_stop();
      @(posedge clk_in);
      #1 pci_stop_n = 1'b0;
      repeat (24) @(negedge clk_in);
      count_toggles(96);
      check("pci up stopped", cnt[4], 32'd0);
      check("pci up level", {pci_up, pin[3]}, 5'h00);
      near("pci free", cnt[3], 23, 25);
      @(posedge clk_in);
      #1 pci_stop_n = 1'b1;
      repeat (24) @(negedge clk_in);
      count_toggles(96);
      near("pci up restart", cnt[4], 23, 25);
   endtask
   // Mid-run power-up with mode one: shared pin drives a reference, PCI stop is ignored
   task automatic t_mode();
      @(posedge clk_in);
      #1 rst_n_in = 1'b0;
      strap = 5'h13;
      pci_stop_n = 1'b0;
      repeat (3) @(posedge clk_in);
      #1 rst_n_in = 1'b1;
      check("oe_n after reset", pin_oe_n, 5'h1f);
      wait_done();
      check("code again", code, 4'h3);
      check("mode one", mode, 1'h1);
      check("ref a oe_n on", ref_oe_n, 1'h0);
      count_toggles(96);
      near("pci up no stop", cnt[4], 47, 49);
      near("pci free by two", cnt[3], 47, 49);
      near("ref b again", cnt[2], 26, 29);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      fails = 0;
      num_checks = 0;
      rst_n_in = 1'b0;
      clk_stop_n = 1'b1;
      serial_sel = 1'b0;
      serial_code = 4'h0;
      strap = 5'h0d;
      pci_stop_n = 1'b1;
      repeat (3) @(posedge clk_in);
      #1 rst_n_in = 1'b1;
      t_strap();
      t_rates();
      t_ratio();
      t_clk_stop();
      t_pci_stop();
      t_mode();
      tally_and_finish();
   end
endmodule
